/* File: lsr_consts.svh */
// Constants for the light sensor range and result register block
// What this block does
// RULE1: Range bits 3:2 pick ranges one to four, 2000 to 128000 lux.
// RULE2: Ranges one and two run the oscillator at half speed, others full.
// RULE3: Control register at 01 is read/write; range is its only function.
// RULE4: Light result is a signed 16-bit count in two read-only bytes.
// RULE5: Light count low byte sits at 04, high byte at 05.
// RULE6: Light count registers update once at the end of every integration.
// RULE7: 16-bit integration cycle count, low byte at 06, high byte at 07.
// RULE8: Cycle counter advances once per oscillator cycle while integrating.
// RULE9: Integration end moves the counter value into the cycle count bytes; internal timing loads zero instead.
// RULE10: Cycle count bytes hold a valid value only in external timing mode.
// RULE11: Internal timing caps the light count at 2^n, n = 3, 7, 11 or 15.
// RULE12: Master picks internal or external timing with the timingExternal input.
// RULE13: Width bits 1:0 give 65536, 4096, 256 or 16 cycles per conversion.
// RULE14: External mode: address bit 7 write ends and restarts integration.
// RULE15: Cycle counter clears to zero at the start of every integration.
`ifndef LSR_CONSTS_SVH
`define LSR_CONSTS_SVH

`define LSR_ADDR_CONTROL    8'h01
`define LSR_ADDR_LIGHT_LO   8'h04
`define LSR_ADDR_LIGHT_HI   8'h05
`define LSR_ADDR_CYCLE_LO   8'h06
`define LSR_ADDR_CYCLE_HI   8'h07
`define LSR_SYNC_ADDR_BIT   7
`define LSR_RANGE_LSB       2
`define LSR_RANGE_MSB       3
`define LSR_CONTROL_RESET   2'h0
`define LSR_READ_UNMAPPED   8'h00

`define LSR_LUX_RANGE1      18'h007D0
`define LSR_LUX_RANGE2      18'h01F40
`define LSR_LUX_RANGE3      18'h07D00
`define LSR_LUX_RANGE4      18'h1F400

`define LSR_LAST_W0         16'hFFFF
`define LSR_LAST_W1         16'h0FFF
`define LSR_LAST_W2         16'h00FF
`define LSR_LAST_W3         16'h000F
`define LSR_MAX_W0          17'h08000
`define LSR_MAX_W1          17'h00800
`define LSR_MAX_W2          17'h00080
`define LSR_MAX_W3          17'h00008

`define LSR_CLK_HZ          200000000
`define LSR_OSC_FULL_HZ     655000
`define LSR_OSC_HALF_HZ     327000
`define LSR_OSC_FULL_DIV    (`LSR_CLK_HZ / `LSR_OSC_FULL_HZ)
`define LSR_OSC_HALF_DIV    (2 * `LSR_OSC_FULL_DIV)

`endif

/* File: lsr_pkg.sv */
// Types shared by the light sensor register block
`default_nettype none
package lsr_pkg;
  typedef logic [1:0] lsr_range_t;
  typedef logic [1:0] lsr_width_t;
  typedef enum logic [0:0] {LSR_IDLE, LSR_INTEG} lsr_state_t;
endpackage : lsr_pkg
`default_nettype wire

/* File: lsr_osc_gen.sv */
// Conversion oscillator model: one tick per oscillator period
`default_nettype none
`include "lsr_consts.svh"
module lsr_osc_gen (
  input  wire logic clk,
  input  wire logic rst_n,
  input  wire logic clkEn,
  input  wire logic fullSpeed,
  output var  logic tick
);
  import lsr_pkg::*;

  localparam logic [9:0] FULL_LAST = 10'(`LSR_OSC_FULL_DIV - 1);
  localparam logic [9:0] HALF_LAST = 10'(`LSR_OSC_HALF_DIV - 1);

  logic [9:0] divCount;
  wire  logic [9:0] lastCount = fullSpeed ? FULL_LAST : HALF_LAST; // [RULE2]
  // Speed change takes effect at once, so a period may run short
  wire  logic wrap = (divCount >= lastCount);

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      divCount <= 10'h000;
      tick     <= 1'b0;
    end else if (clkEn) begin
      divCount <= wrap ? 10'h000 : divCount + 10'h001;
      tick     <= wrap;
    end
  end
endmodule : lsr_osc_gen
`default_nettype wire

/* File: lsr_regs.sv */
// Range control, light count and cycle count registers of the light sensor
`default_nettype none
`include "lsr_consts.svh"
module lsr_regs (
  input  wire logic              clk,
  input  wire logic              rst_n,
  input  wire logic              clkEn,
  input  wire logic [7:0]        regAddr,
  input  wire logic [7:0]        regWrData,
  input  wire logic              regWrEn,
  input  wire logic              regRdEn,
  output var  logic [7:0]        regRdData,
  input  wire logic              convEnable,
  input  wire logic              timingExternal,
  input  wire lsr_pkg::lsr_width_t widthSel,
  input  wire logic [15:0]       adcResult,
  output var  lsr_pkg::lsr_range_t rangeSel,
  output var  logic              oscFullSpeed,
  output var  logic [17:0]       fullScaleLux,
  output var  logic              integrationDone,
  output var  logic              cycleCountValid
);
  import lsr_pkg::*;

  lsr_state_t  state;
  logic [15:0] cycleCounter;
  logic [15:0] lightCount;
  logic [15:0] cycleCount;
  logic        oscTick;

  lsr_osc_gen u_osc (
    .clk       (clk),
    .rst_n     (rst_n),
    .clkEn     (clkEn),
    .fullSpeed (oscFullSpeed),
    .tick      (oscTick)
  );

  // Register port decode
  wire logic wrControl = regWrEn && (regAddr == `LSR_ADDR_CONTROL); // [RULE3]
  wire logic syncCmd   = regWrEn && regAddr[`LSR_SYNC_ADDR_BIT]; // [RULE14]
  wire lsr_range_t newRange =
    regWrData[`LSR_RANGE_MSB:`LSR_RANGE_LSB]; // [RULE1]

  // Width selects the last count of a conversion and the count ceiling
  wire logic [15:0] lastCount =
    (widthSel == 2'h0) ? `LSR_LAST_W0 :
    (widthSel == 2'h1) ? `LSR_LAST_W1 :
    (widthSel == 2'h2) ? `LSR_LAST_W2 : `LSR_LAST_W3; // [RULE13]
  wire logic [16:0] maxCount =
    (widthSel == 2'h0) ? `LSR_MAX_W0 :
    (widthSel == 2'h1) ? `LSR_MAX_W1 :
    (widthSel == 2'h2) ? `LSR_MAX_W2 : `LSR_MAX_W3; // [RULE11]

  // Integration end: counted in internal mode, commanded in external
  wire logic intEnd = !timingExternal && oscTick &&
                      (cycleCounter == lastCount); // [RULE12] [RULE13]
  wire logic extEnd = timingExternal && syncCmd; // [RULE12] [RULE14]
  wire logic endInteg = (state == LSR_INTEG) && (intEnd || extEnd);

  // Signed clamp to the ceiling, internal mode only
  wire logic signed [16:0] adcWide  = $signed({adcResult[15], adcResult});
  wire logic signed [16:0] maxWide  = $signed(maxCount);
  wire logic               overMax  = adcWide > maxWide;
  wire logic [15:0] lightCapture =
    (!timingExternal && overMax) ? maxCount[15:0] : adcResult; // [RULE11]

  // Counter saturates, so an over-long external period reads all ones
  wire logic [15:0] counterInc =
    (cycleCounter == 16'hFFFF) ? cycleCounter : cycleCounter + 16'h0001;
  wire logic [15:0] cycleCapture =
    timingExternal ? counterInc : 16'h0000; // [RULE10]

  wire logic [17:0] luxSel =
    (newRange == 2'h0) ? `LSR_LUX_RANGE1 :
    (newRange == 2'h1) ? `LSR_LUX_RANGE2 :
    (newRange == 2'h2) ? `LSR_LUX_RANGE3 : `LSR_LUX_RANGE4; // [RULE1]

  // Read decode
  wire logic [7:0] rdMux =
    (regAddr == `LSR_ADDR_CONTROL)  ? {4'h0, rangeSel, 2'h0} : // [RULE3]
    (regAddr == `LSR_ADDR_LIGHT_LO) ? lightCount[7:0]  : // [RULE5]
    (regAddr == `LSR_ADDR_LIGHT_HI) ? lightCount[15:8] : // [RULE4] [RULE5]
    (regAddr == `LSR_ADDR_CYCLE_LO) ? cycleCount[7:0]  : // [RULE7]
    (regAddr == `LSR_ADDR_CYCLE_HI) ? cycleCount[15:8] : // [RULE7]
    `LSR_READ_UNMAPPED;

  lsr_state_t next_state;
  always_comb begin
    next_state = state;
    case (state)
      LSR_IDLE:  if (convEnable) next_state = LSR_INTEG;
      LSR_INTEG: if (!convEnable) next_state = LSR_IDLE;
      default:   next_state = LSR_IDLE;
    endcase
  end

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      rangeSel     <= `LSR_CONTROL_RESET;
      oscFullSpeed <= 1'b0;
      fullScaleLux <= `LSR_LUX_RANGE1;
    end else if (clkEn && wrControl) begin
      rangeSel     <= newRange; // [RULE1] [RULE3]
      oscFullSpeed <= newRange[1]; // [RULE2]
      fullScaleLux <= luxSel; // [RULE1]
    end
  end

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      regRdData <= 8'h00;
    end else if (clkEn && regRdEn) begin
      regRdData <= rdMux;
    end
  end

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      state        <= LSR_IDLE;
      cycleCounter <= 16'h0000;
    end else if (clkEn) begin
      state <= next_state;
      if (state != LSR_INTEG || endInteg) begin
        cycleCounter <= 16'h0000; // [RULE15]
      end else if (oscTick) begin
        cycleCounter <= counterInc; // [RULE8]
      end
    end
  end

  // A tick in the same cycle as an external sync counts into the capture
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      lightCount      <= 16'h0000;
      cycleCount      <= 16'h0000;
      integrationDone <= 1'b0;
      cycleCountValid <= 1'b0;
    end else if (clkEn) begin
      integrationDone <= endInteg;
      if (endInteg) begin
        lightCount      <= lightCapture; // [RULE4] [RULE6]
        cycleCount      <= extEnd ?
                           (oscTick ? counterInc : cycleCounter) :
                           cycleCapture; // [RULE9] [RULE10]
        cycleCountValid <= timingExternal; // [RULE10]
      end
    end
  end
endmodule : lsr_regs
`default_nettype wire

/* File: lsr_regs_properties.sv */
// Port checker for the light sensor register block
`default_nettype none
module lsr_regs_chk (
  input wire logic                clk,
  input wire logic                rst_n,
  input wire logic                clkEn,
  input wire logic                regWrEn,
  input wire logic                regRdEn,
  input wire logic                convEnable,
  input wire logic                timingExternal,
  input wire logic                oscFullSpeed,
  input wire logic                integrationDone,
  input wire logic                cycleCountValid,
  input wire logic [7:0]          regAddr,
  input wire logic [7:0]          regWrData,
  input wire logic [7:0]          regRdData,
  input wire lsr_pkg::lsr_range_t rangeSel,
  input wire logic [17:0]         fullScaleLux
);
  import lsr_pkg::*;
  default clocking @(posedge clk); endclocking
  default disable iff (!rst_n);
  wire logic wr = clkEn && regWrEn;
  wire logic rd = clkEn && regRdEn;
  wire logic [1:0] wrRange = regWrData[3:2];
  // Integrating already: enable seen at the previous edge
  wire logic armed = convEnable && clkEn && rst_n;
  chk_lux_table: assert property (fullScaleLux ==
    (rangeSel[1] ? (rangeSel[0] ? 18'h1F400 : 18'h07D00)
    : (rangeSel[0] ? 18'h01F40 : 18'h007D0))) else $error("bad lux");
  chk_osc_speed: assert property (oscFullSpeed == rangeSel[1])
    else $error("bad osc speed");
  chk_ctrl_write: assert property (wr && regAddr == 8'h01 |=>
    rangeSel == $past(wrRange)) else $error("range not taken");
  chk_ctrl_read: assert property (rd && regAddr == 8'h01 |=>
    regRdData == {4'h0, $past(rangeSel), 2'h0}) else $error("bad read");
  chk_unmapped_read: assert property (rd && regAddr == 8'h02 |=>
    regRdData == 8'h00) else $error("unmapped read");
  chk_read_hold: assert property (!rd |=> $stable(regRdData))
    else $error("read data moved");
  chk_sync_done: assert property (wr && regAddr[7]
    && timingExternal && convEnable && $past(armed) |=> integrationDone)
    else $error("no capture");
  // Enable low must freeze range, lux, read data and the done strobe
  chk_enable_freeze: assert property (!clkEn |=>
    $stable(rangeSel) && $stable(fullScaleLux) && $stable(regRdData)
    && $stable(integrationDone)) else $error("state moved while frozen");
  chk_valid_mode: assert property (integrationDone |->
    cycleCountValid == $past(timingExternal)) else $error("bad valid");
  cover property (integrationDone && cycleCountValid);
  cover property (integrationDone && !cycleCountValid);
  cover property (wr && regAddr == 8'h01 && wrRange == 2'h3);
endmodule : lsr_regs_chk
bind lsr_regs lsr_regs_chk u_chk (.clk, .rst_n, .clkEn, .regWrEn, .regRdEn,
  .convEnable, .timingExternal, .oscFullSpeed, .integrationDone,
  .cycleCountValid, .regAddr, .regWrData, .regRdData, .rangeSel,
  .fullScaleLux);
`default_nettype wire

/* File: lsr_master.sv */
// Bus master model issuing register strobes
`default_nettype none
module lsr_master (
  input  wire logic       clk,
  input  wire logic [7:0] regRdData,
  output var  logic [7:0] regAddr,
  output var  logic [7:0] regWrData,
  output var  logic       regWrEn,
  output var  logic       regRdEn
);
  timeunit 1ns;
  timeprecision 100ps;
  initial begin
    {regAddr, regWrData, regWrEn, regRdEn} = 18'h0;
  end
  // One-cycle strobe; released address and data inverted so stale values never match, strobes cleared
  task automatic access(input logic [7:0] a, d, input logic w,
                        output logic [7:0] q);
    @(posedge clk) #1;
    {regAddr, regWrData, regWrEn, regRdEn} = {a, d, w, !w};
    @(posedge clk) #1;
    q = regRdData;
    {regAddr, regWrData, regWrEn, regRdEn} = {~a, ~d, 2'h0};
  endtask : access
endmodule : lsr_master
`default_nettype wire

/* File: lsr_tb.sv */
// Bench for the light sensor range and result registers
`default_nettype none
module testbench;
  timeunit 1ns;
  timeprecision 100ps;
  import lsr_pkg::*;
  typedef struct packed {lsr_range_t r; logic [17:0] lux;} lsr_row_t;
  lsr_row_t rows [4] = '{'{2'h1, 18'h01F40}, '{2'h3, 18'h1F400},
    '{2'h2, 18'h07D00}, '{2'h0, 18'h007D0}};
  logic clk = 0, rst_n = 0, convEnable = 0, timingExternal = 0, clkEn = 1;
  logic regWrEn, regRdEn, oscFullSpeed, integrationDone, cycleCountValid;
  logic [7:0] regAddr, regWrData, regRdData, q;
  logic [15:0] adcResult = 16'h0100;
  logic [17:0] fullScaleLux;
  lsr_range_t rangeSel;
  int mismatches = 0, n_tests = 0, t;
  always #2.5 clk = ~clk;
  lsr_master bus (.clk, .regRdData, .regAddr, .regWrData, .regWrEn,
    .regRdEn);
  lsr_regs dut (.clk, .rst_n, .clkEn, .regAddr, .regWrData, .regWrEn,
    .regRdEn, .regRdData, .convEnable, .timingExternal, .widthSel(2'h3),
    .adcResult, .rangeSel, .oscFullSpeed, .fullScaleLux, .integrationDone,
    .cycleCountValid);
  task automatic chk(input logic [31:0] s, e);
    n_tests++;
    if (s !== e) begin
      mismatches++;
      $display("FAIL %0t %h %h", $time, s, e);
    end
  endtask : chk
  task automatic results;
    $display("%0d compares %0d mismatches", n_tests, mismatches);
    if (mismatches == 0 && n_tests > 0) $display("NO MISMATCHES");
    else $display("MISMATCHES SEEN");
    $finish;
  endtask : results
  task automatic acc(input logic [7:0] a, d, input logic w);
    bus.access(a, d, w, q);
  endtask : acc
  task automatic waitDone;
    t = 0;
    do begin
      @(posedge clk) #1 t++;
    end while (integrationDone !== 1'b1 && t < 6000);
    if (integrationDone !== 1'b1) begin
      mismatches++;
      results;
    end
  endtask : waitDone
  initial begin
    repeat (4) @(posedge clk);
    #1 rst_n = 1;
    chk(fullScaleLux, 18'h007D0);
    foreach (rows[i]) begin
      acc(8'h01, {4'hF, rows[i].r, 2'h3}, 1'b1);
      chk(fullScaleLux, rows[i].lux);
      chk(oscFullSpeed, rows[i].r[1]);
      acc(8'h01, 8'h00, 1'b0);
      chk(q, {4'h0, rows[i].r, 2'h0});
    end
    $display("range test done");
    // Write with enable low must not land
    clkEn = 0;
    acc(8'h01, 8'h0C, 1'b1);
    chk({rangeSel, fullScaleLux}, {2'h0, 18'h007D0});
    clkEn = 1;
    $display("enable test done");
    acc(8'h01, 8'h08, 1'b1);
    acc(8'h02, 8'h00, 1'b0);
    chk(q, 8'h00);
    adcResult = 16'hA5C3;
    {timingExternal, convEnable} = 2'h3;
    acc(8'h80, 8'h00, 1'b1);
    // Exactly three full-speed ticks of 305 clk between the syncs
    repeat (913) @(posedge clk);
    acc(8'h80, 8'h00, 1'b1);
    chk({integrationDone, cycleCountValid}, 2'h3);
    acc(8'h06, 8'h00, 1'b0);
    chk(q, 8'h03);
    acc(8'h07, 8'h00, 1'b0);
    chk(q, 8'h00);
    acc(8'h04, 8'h00, 1'b0);
    chk(q, 8'hC3);
    acc(8'h05, 8'hFF, 1'b1);
    acc(8'h05, 8'h00, 1'b0);
    chk(q, 8'hA5);
    $display("external test done");
    timingExternal = 0;
    adcResult = 16'h0100;
    waitDone;
    waitDone;
    chk(t, 16 * 305);
    chk(cycleCountValid, 1'b0);
    acc(8'h04, 8'h00, 1'b0);
    chk(q, 8'h08);
    acc(8'h06, 8'h00, 1'b0);
    chk(q, 8'h00);
    $display("internal test done");
    rst_n = 0;
    #1 chk(fullScaleLux, 18'h007D0);
    @(posedge clk) #1 rst_n = 1;
    acc(8'h01, 8'h00, 1'b0);
    chk({q, rangeSel, oscFullSpeed}, 11'h0);
    $display("reset test done");
    results;
  end
endmodule : testbench
`default_nettype wire
